// [hdl/emp_pkg.sv]
package emp_pkg;
  localparam int EMP_ADDR_W = 22;
  localparam int EMP_DATA_W = 32;
  localparam int EMP_PIN_A_W = 20;
  localparam int EMP_CNT_W = 6;
  localparam int EMP_NUM_CS = 4;
  localparam int EMP_CS_SEL_LSB = 20;
  localparam logic [1:0] EMP_CS_SDRAM = 2'h0;
  localparam logic [EMP_NUM_CS-1:0] EMP_CS_IS_SYNC = 4'h1;
  localparam logic [1:0] EMP_WIDTH_32 = 2'h0;
  localparam logic [1:0] EMP_WIDTH_16 = 2'h1;
  localparam logic [1:0] EMP_WIDTH_8 = 2'h2;
  localparam logic [3:0] EMP_SD_NOP = 4'h7;
  localparam logic [3:0] EMP_SD_ACT = 4'h3;
  localparam logic [3:0] EMP_SD_READ = 4'h5;
  localparam logic [3:0] EMP_SD_WRITE = 4'h4;
  localparam logic [3:0] EMP_SD_PRE = 4'h2;
  localparam logic [3:0] EMP_SD_DESEL = 4'hf;
  localparam logic [EMP_CNT_W-1:0] EMP_CNT_ONE = 6'h01;
  localparam logic [EMP_CNT_W-1:0] EMP_SD_TRCD = 6'h02;
  localparam logic [EMP_CNT_W-1:0] EMP_SD_TCAS = 6'h02;
  localparam logic [EMP_CNT_W-1:0] EMP_SD_TRP = 6'h02;
  localparam int EMP_SD_COL_W = 10;
  localparam int EMP_SD_ROW_W = 12;
endpackage

// [hdl/emp_phase_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module emp_phase_timer
  import emp_pkg::*;
#(
  parameter int CNT_W = EMP_CNT_W
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic load,
  input wire logic [CNT_W-1:0] length,
  output logic done
);
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] len_eff;

  // A programmed zero still gives a one-cycle phase.
  assign len_eff = (length == '0) ? CNT_W'(1) : length;
  // Done must not look at load: the sequencer derives load from done.
  assign done = (count_r == CNT_W'(1));

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      count_r <= '0;
    end else if (load) begin
      count_r <= len_eff;
    end else if (count_r != '0) begin
      count_r <= count_r - CNT_W'(1);
    end
  end
endmodule // emp_phase_timer
`default_nettype wire

// [hdl/emp_external_memory_port.sv]
`timescale 1ns/1ps
`default_nettype none
module emp_external_memory_port
  import emp_pkg::*;
#(
  parameter int ADDR_W = EMP_ADDR_W,
  parameter int DATA_W = EMP_DATA_W,
  parameter int CNT_W = EMP_CNT_W
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic host_req,
  input wire logic host_write,
  input wire logic [ADDR_W-1:0] host_addr,
  input wire logic [DATA_W-1:0] host_wdata,
  output logic host_ready,
  output logic host_rvalid,
  output logic [DATA_W-1:0] host_rdata,
  input wire logic [CNT_W-1:0] setup_len,
  input wire logic [CNT_W-1:0] strobe_len,
  input wire logic [CNT_W-1:0] hold_len,
  input wire logic strobe_on_select,
  input wire logic [1:0] async_width,
  output logic [EMP_NUM_CS-1:0] cs_n,
  output logic we_n,
  output logic oe_n,
  output logic rnw,
  output logic [EMP_PIN_A_W-1:0] addr_out,
  output logic bank_address_bit_one,
  output logic bank_address_bit_zero,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe_n,
  input wire logic [DATA_W-1:0] data_in,
  output logic [3:0] sd_cmd,
  output logic sd_cke
);
  if (ADDR_W < EMP_CS_SEL_LSB + 2 || CNT_W < 2 || DATA_W != EMP_DATA_W) begin : g_bad_params
    $error("emp_external_memory_port: unsupported parameters");
  end

  typedef enum logic [7:0] {
    EMP_IDLE = 8'h01, EMP_SETUP = 8'h02, EMP_STROBE = 8'h04, EMP_HOLD = 8'h08,
    EMP_SD_ACTV = 8'h10, EMP_SD_ACC = 8'h20, EMP_SD_WAIT = 8'h40, EMP_SD_PREC = 8'h80
  } emp_state_e;

  emp_state_e state_r;
  emp_state_e state_nxt;
  logic [ADDR_W-1:0] addr_r;
  logic write_r;
  logic [1:0] cs_sel_r;
  logic [1:0] req_sel;
  logic timer_load;
  logic [CNT_W-1:0] timer_len;
  logic timer_done;
  logic take;
  logic same_window;
  logic [CNT_W-1:0] sd_cnt_r;
  logic [EMP_NUM_CS-1:0] cs_n_nxt;
  logic [EMP_PIN_A_W+1:0] async_pins;
  logic [1:0] cur_sel;
  logic [ADDR_W-1:0] addr_now;
  logic write_now;

  // Window decode is fixed in hardware; windows are 32-bit word ranges.
  assign req_sel = host_addr[EMP_CS_SEL_LSB +: 2];
  assign host_ready = (state_r == EMP_IDLE);
  assign take = host_req && host_ready;
  // A second access to an already selected window keeps its select low while strobe_on_select is clear.
  assign same_window = host_req && (req_sel == cs_sel_r);
  // Pins launched at the take edge must follow the new request, not the previous one.
  assign cur_sel = take ? req_sel : cs_sel_r;
  assign addr_now = take ? host_addr : addr_r;
  assign write_now = take ? host_write : write_r;

  always_comb begin
    timer_load = 1'b0;
    timer_len = setup_len;
    state_nxt = state_r;
    case (state_r)
      EMP_IDLE: begin
        if (take) begin
          if (EMP_CS_IS_SYNC[req_sel]) begin
            state_nxt = EMP_SD_ACTV;
          end else begin
            state_nxt = EMP_SETUP;
            timer_load = 1'b1;
          end
        end
      end
      EMP_SETUP: begin
        if (timer_done) begin
          state_nxt = EMP_STROBE;
          timer_load = 1'b1;
          timer_len = strobe_len;
        end
      end
      EMP_STROBE: begin
        if (timer_done) begin
          state_nxt = EMP_HOLD;
          timer_load = 1'b1;
          timer_len = hold_len;
        end
      end
      EMP_HOLD: begin
        if (timer_done) begin
          state_nxt = EMP_IDLE;
        end
      end
      EMP_SD_ACTV: begin
        if (sd_cnt_r == '0) begin
          state_nxt = EMP_SD_ACC;
        end
      end
      EMP_SD_ACC: begin
        state_nxt = EMP_SD_WAIT;
      end
      EMP_SD_WAIT: begin
        if (sd_cnt_r == '0) begin
          state_nxt = EMP_SD_PREC;
        end
      end
      EMP_SD_PREC: begin
        if (sd_cnt_r == '0) begin
          state_nxt = EMP_IDLE;
        end
      end
      default: begin
        state_nxt = EMP_IDLE;
      end
    endcase
  end

  emp_phase_timer #(.CNT_W(CNT_W)) u_timer (
    .mclk(mclk),
    .resetn(resetn),
    .load(timer_load),
    .length(timer_len),
    .done(timer_done)
  );

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_r <= EMP_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      addr_r <= '0;
      write_r <= 1'b0;
      cs_sel_r <= EMP_CS_SDRAM;
      data_out <= '0;
    end else if (take) begin
      addr_r <= host_addr;
      write_r <= host_write;
      cs_sel_r <= req_sel;
      data_out <= host_wdata;
    end
  end

  // Fixed SDRAM command spacing, counted in controller cycles.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sd_cnt_r <= '0;
    end else if (take && EMP_CS_IS_SYNC[req_sel]) begin
      sd_cnt_r <= EMP_SD_TRCD - EMP_CNT_ONE;
    end else if (state_r == EMP_SD_ACC) begin
      sd_cnt_r <= write_r ? '0 : EMP_SD_TCAS - EMP_CNT_ONE;
    end else if (state_r == EMP_SD_WAIT && sd_cnt_r == '0) begin
      sd_cnt_r <= EMP_SD_TRP - EMP_CNT_ONE;
    end else if (sd_cnt_r != '0) begin
      sd_cnt_r <= sd_cnt_r - EMP_CNT_ONE;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sd_cmd <= EMP_SD_NOP;
    end else begin
      case (state_nxt)
        EMP_SD_ACTV: sd_cmd <= (state_r == EMP_IDLE) ? EMP_SD_ACT : EMP_SD_NOP;
        EMP_SD_ACC: sd_cmd <= write_r ? EMP_SD_WRITE : EMP_SD_READ;
        EMP_SD_PREC: sd_cmd <= (state_r == EMP_SD_WAIT) ? EMP_SD_PRE : EMP_SD_NOP;
        default: sd_cmd <= EMP_SD_NOP;
      endcase
    end
  end

  // Async pin word: narrow memories shift the word address down by one or two pins,
  // so the freed bank pins carry the lowest address bits.
  always_comb begin
    case (async_width)
      EMP_WIDTH_16: async_pins = {1'b0, addr_now[EMP_PIN_A_W-1:1], addr_now[0], 1'b0};
      EMP_WIDTH_8: async_pins = {2'h0, addr_now[EMP_PIN_A_W-1:2], addr_now[1:0]};
      default: async_pins = {addr_now[EMP_PIN_A_W-1:0], 2'h0};
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      addr_out <= '0;
      bank_address_bit_one <= 1'b0;
      bank_address_bit_zero <= 1'b0;
    end else if (state_nxt == EMP_SETUP) begin
      addr_out <= async_pins[EMP_PIN_A_W+1:2];
      bank_address_bit_one <= async_pins[1];
      bank_address_bit_zero <= async_pins[0];
    end else if (state_nxt == EMP_SD_ACTV && state_r == EMP_IDLE) begin
      addr_out <= EMP_PIN_A_W'(host_addr[EMP_SD_COL_W +: EMP_SD_ROW_W]);
      // Row and column use up the whole host address, so only bank zero is reachable.
      bank_address_bit_one <= 1'b0;
      bank_address_bit_zero <= 1'b0;
    end else if (state_nxt == EMP_SD_ACC) begin
      addr_out <= EMP_PIN_A_W'(addr_r[EMP_SD_COL_W-1:0]);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cs_n <= '1;
      we_n <= 1'b1;
      oe_n <= 1'b1;
      rnw <= 1'b1;
      data_oe_n <= 1'b1;
      sd_cke <= 1'b0;
    end else begin
      sd_cke <= 1'b1;
      cs_n <= cs_n_nxt;
      we_n <= !(state_nxt == EMP_STROBE && write_r);
      oe_n <= !(state_nxt == EMP_STROBE && !write_r);
      rnw <= (state_nxt == EMP_IDLE) ? 1'b1 : !write_now;
      data_oe_n <= !(write_now && state_nxt inside {EMP_SETUP, EMP_STROBE, EMP_HOLD});
    end
  end

  always_comb begin
    cs_n_nxt = '1;
    case (state_nxt)
      EMP_SETUP, EMP_HOLD: cs_n_nxt[cur_sel] = strobe_on_select;
      EMP_STROBE: cs_n_nxt[cur_sel] = 1'b0;
      EMP_SD_ACTV, EMP_SD_ACC, EMP_SD_WAIT, EMP_SD_PREC: cs_n_nxt[cur_sel] = 1'b0;
      default: begin
        // The SDRAM select stays low at idle; async selects release unless a same-window request waits with strobe_on_select clear.
        cs_n_nxt[EMP_CS_SDRAM] = 1'b0;
        if (same_window && !EMP_CS_IS_SYNC[cs_sel_r] && !strobe_on_select) begin
          cs_n_nxt[cs_sel_r] = 1'b0;
        end
      end
    endcase
    if (state_nxt inside {EMP_SETUP, EMP_STROBE, EMP_HOLD}) begin
      cs_n_nxt[EMP_CS_SDRAM] = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      host_rdata <= '0;
      host_rvalid <= 1'b0;
    end else begin
      host_rvalid <= 1'b0;
      if (state_r == EMP_STROBE && timer_done && !write_r) begin
        host_rdata <= data_in;
        host_rvalid <= 1'b1;
      end else if (state_r == EMP_SD_WAIT && sd_cnt_r == '0 && !write_r) begin
        host_rdata <= data_in;
        host_rvalid <= 1'b1;
      end
    end
  end
endmodule // emp_external_memory_port
`default_nettype wire

// [verification/emp_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module emp_checker
  import emp_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic host_req,
  input wire logic host_ready,
  input wire logic [EMP_ADDR_W-1:0] host_addr,
  input wire logic host_rvalid,
  input wire logic [EMP_CNT_W-1:0] strobe_len,
  input wire logic strobe_on_select,
  input wire logic [EMP_NUM_CS-1:0] cs_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic rnw,
  input wire logic data_oe_n,
  input wire logic [3:0] sd_cmd
);
  logic [EMP_CNT_W-1:0] stb_cnt_r;
  logic take;
  assign take = host_req && host_ready;
  // Counts strobe cycles so a zero length can be checked as one cycle.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) stb_cnt_r <= '0;
    else if (!we_n || !oe_n) stb_cnt_r <= stb_cnt_r + 1'b1;
    else stb_cnt_r <= '0;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  property p_we_strobe; !we_n |-> oe_n && !data_oe_n && !rnw; endproperty
  a_we_strobe: assert property (p_we_strobe)
    else $error("write strobe outside a write");
  property p_oe_strobe; !oe_n |-> we_n && data_oe_n && rnw; endproperty
  a_oe_strobe: assert property (p_oe_strobe)
    else $error("read strobe outside a read");
  property p_stb_len;
    $rose(we_n && oe_n) |-> stb_cnt_r == ((strobe_len == '0) ? EMP_CNT_ONE : strobe_len);
  endproperty
  a_stb_len: assert property (p_stb_len)
    else $error("strobe length wrong");
  property p_sel_in_stb; !we_n || !oe_n |-> cs_n[3:1] != 3'h7; endproperty
  a_sel_in_stb: assert property (p_sel_in_stb)
    else $error("no select during strobe");
  property p_sel_strobe; strobe_on_select && we_n && oe_n |-> cs_n[3:1] == 3'h7; endproperty
  a_sel_strobe: assert property (p_sel_strobe)
    else $error("select low outside strobe");
  property p_idle; $past(resetn) && host_ready && !host_req |-> cs_n == 4'he; endproperty
  a_idle: assert property (p_idle)
    else $error("selects wrong at idle");
  property p_launch;
    take && host_addr[21:20] != EMP_CS_SDRAM && !strobe_on_select
      |=> !cs_n[$past(host_addr[21:20])] ##0 cs_n[0];
  endproperty
  a_launch: assert property (p_launch)
    else $error("window select missing");
  property p_sd_act; take && host_addr[21:20] == EMP_CS_SDRAM |=> sd_cmd == EMP_SD_ACT; endproperty
  a_sd_act: assert property (p_sd_act)
    else $error("no activate after sdram take");
  property p_sd_rcd;
    sd_cmd == EMP_SD_READ || sd_cmd == EMP_SD_WRITE |-> $past(sd_cmd, 2) == EMP_SD_ACT;
  endproperty
  a_sd_rcd: assert property (p_sd_rcd)
    else $error("column command not two after activate");
  property p_rvalid; $rose(oe_n) |-> host_rvalid; endproperty
  a_rvalid: assert property (p_rvalid)
    else $error("read data not returned after strobe");
  c_write: cover property ($rose(we_n));
  c_read: cover property ($rose(oe_n));
  c_sdram: cover property (sd_cmd == EMP_SD_READ);
endmodule // emp_checker
bind emp_external_memory_port emp_checker i_emp_checker (.mclk, .resetn, .host_req, .host_ready,
  .host_addr, .host_rvalid, .strobe_len, .strobe_on_select, .cs_n, .we_n, .oe_n, .rnw, .data_oe_n,
  .sd_cmd);
`default_nettype wire

// [verification/emp_memory_model.sv]
`timescale 1ns/1ps
`default_nettype none
module emp_memory_model
  import emp_pkg::*;
(
  input wire logic mclk,
  input wire logic [EMP_NUM_CS-1:0] cs_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [EMP_PIN_A_W-1:0] addr_out,
  input wire logic bank_address_bit_one,
  input wire logic bank_address_bit_zero,
  input wire logic [EMP_DATA_W-1:0] data_out,
  output logic [EMP_DATA_W-1:0] data_in,
  input wire logic [3:0] sd_cmd
);
  logic [EMP_DATA_W-1:0] mem [0:31];
  logic [EMP_DATA_W-1:0] last_r = '0;
  logic [4:0] a_idx, col_r;
  logic [1:0] rd_sh = 2'h0;
  logic drive;
  assign a_idx = {1'b0, bank_address_bit_one, bank_address_bit_zero, addr_out[1:0]};
  // The sdram drives only in the one cycle that ends two clocks after the read command.
  assign drive = (!oe_n && cs_n[3:1] != 3'h7) || rd_sh[1];
  // Released data shows the inverse of the last word, so a late sample cannot match by luck.
  assign data_in = drive ? (rd_sh[1] ? mem[col_r] : mem[a_idx]) : ~last_r;
  always @(posedge mclk) begin
    if (!we_n && cs_n[3:1] != 3'h7) mem[a_idx] <= data_out;
    if (sd_cmd == EMP_SD_WRITE) mem[{1'b1, addr_out[3:0]}] <= data_out;
    if (sd_cmd == EMP_SD_READ) col_r <= {1'b1, addr_out[3:0]};
    rd_sh <= {rd_sh[0], sd_cmd == EMP_SD_READ};
    if (drive) last_r <= data_in;
  end
endmodule // emp_memory_model
`default_nettype wire

// [verification/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench
  import emp_pkg::*;
;
  logic mclk, resetn, host_req, host_write, host_ready, host_rvalid, strobe_on_select;
  logic [EMP_ADDR_W-1:0] host_addr;
  logic [EMP_DATA_W-1:0] host_wdata, host_rdata, data_out, data_in, rd;
  logic [EMP_CNT_W-1:0] setup_len, strobe_len, hold_len;
  logic [1:0] async_width;
  logic [EMP_NUM_CS-1:0] cs_n;
  logic [EMP_PIN_A_W-1:0] addr_out;
  logic we_n, oe_n, rnw, bank_address_bit_one, bank_address_bit_zero, data_oe_n, sd_cke;
  logic [3:0] sd_cmd;
  logic [5:0] map;
  int n_fail, n_compared, n_cs, n_stb, n_rv, gaps;
  emp_external_memory_port i_emp_external_memory_port (.mclk, .resetn, .host_req, .host_write,
    .host_addr, .host_wdata, .host_ready, .host_rvalid, .host_rdata, .setup_len, .strobe_len,
    .hold_len, .strobe_on_select, .async_width, .cs_n, .we_n, .oe_n, .rnw, .addr_out,
    .bank_address_bit_one, .bank_address_bit_zero, .data_out, .data_oe_n, .data_in, .sd_cmd,
    .sd_cke);
  emp_memory_model i_emp_memory_model (.mclk, .cs_n, .we_n, .oe_n, .addr_out,
    .bank_address_bit_one, .bank_address_bit_zero, .data_out, .data_in, .sd_cmd);
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  function automatic int eff(input int v);
    return (v == 0) ? 1 : v;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One access; counts select and strobe cycles until the port is ready again.
  task automatic op(input logic wr, input logic [21:0] a, input logic [31:0] d);
    @(negedge mclk);
    host_req = 1'b1;
    host_write = wr;
    host_addr = a;
    host_wdata = d;
    while (!host_ready) @(negedge mclk);
    @(negedge mclk);
    host_req = 1'b0;
    n_cs = 0;
    n_stb = 0;
    n_rv = 0;
    for (int i = 1; i < 40; i++) begin
      if (!cs_n[a[21:20]]) n_cs++;
      if (!we_n || !oe_n) n_stb++;
      if (!we_n || !oe_n) map = {addr_out[3:0], bank_address_bit_one, bank_address_bit_zero};
      if (host_rvalid) n_rv = i;
      if (host_rvalid) rd = host_rdata;
      if (host_ready) break;
      @(negedge mclk);
    end
  endtask
  task automatic t_async();
    logic [21:0] a;
    for (int w = 0; w < 3; w++) begin
      setup_len = 6'(w);
      strobe_len = 6'(w + 1);
      hold_len = 6'(2 - w);
      async_width = 2'(w);
      a = {2'(w + 1), 20'h0002d};
      op(1'b1, a, 32'h5a5a_0000 | 32'(w));
      check(n_cs, eff(w) + w + 1 + eff(2 - w));
      check(n_stb, w + 1);
      check(map[5:2], 4'(a >> w));
      op(1'b0, a, 32'h0);
      check(n_stb, w + 1);
      check(n_rv, 1 + eff(w) + w + 1);
      check(rd, 32'h5a5a_0000 | 32'(w));
      if (w == 1) check(map[1], a[0]);
      if (w == 2) check(map[1:0], a[1:0]);
    end
  endtask
  task automatic t_strobe_sel();
    strobe_on_select = 1'b1;
    op(1'b1, {2'h3, 20'h00011}, 32'h0f0f_1234);
    check(n_cs, 3);
    op(1'b0, {2'h3, 20'h00011}, 32'h0);
    check(n_cs, 3);
    check(rd, 32'h0f0f_1234);
    strobe_on_select = 1'b0;
  endtask
  task automatic t_sdram();
    op(1'b1, {2'h0, 20'h00407}, 32'hc3c3_9696);
    check(sd_cke, 1'b1);
    async_width = 2'h0;
    op(1'b0, {2'h0, 20'h00407}, 32'h0);
    check(n_rv, 6);
    check(n_stb, 0);
    check(rd, 32'hc3c3_9696);
    check(cs_n, 4'he);
  endtask
  task automatic t_b2b();
    @(negedge mclk);
    host_req = 1'b1;
    host_write = 1'b1;
    host_addr = {2'h2, 20'h00003};
    host_wdata = 32'h1111_2222;
    while (!host_ready) @(negedge mclk);
    @(negedge mclk);
    host_addr = {2'h2, 20'h00004};
    host_wdata = 32'h3333_4444;
    gaps = 0;
    while (!host_ready) begin
      if (cs_n[2]) gaps++;
      @(negedge mclk);
    end
    if (cs_n[2]) gaps++;
    @(negedge mclk);
    host_req = 1'b0;
    check(gaps, 0);
    op(1'b0, {2'h2, 20'h00004}, 32'h0);
    check(rd, 32'h3333_4444);
  endtask
  task automatic give_verdict();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    {host_req, host_write, strobe_on_select, resetn} = 4'h0;
    {host_addr, host_wdata, async_width} = '0;
    {setup_len, strobe_len, hold_len} = {6'h01, 6'h01, 6'h01};
    n_fail = 0;
    n_compared = 0;
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    resetn = 1'b1;
    t_async();
    t_strobe_sel();
    t_sdram();
    t_b2b();
    give_verdict();
  end
  initial begin
    repeat (3000) @(posedge mclk);
    n_fail++;
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
